/* File: verilog/pss_top.sv */
// Local design decisions: the Avalon-MM slave port and the register offsets.
`include "pss_map.svh"
module pss_top import pss_pkg::*; #(
  parameter int P_UNIT_CYC = `PSS_FILT_UNIT_CYC
) (
  input wire logic i_clk, // 40 MHz clock
  input wire logic i_rst, // Sync reset, active high
  input wire logic [7:0] i_avs_address, // Byte address
  input wire logic i_avs_read, // Read request
  input wire logic i_avs_write, // Write request
  input wire logic [31:0] i_avs_writedata, // Write data
  input wire logic [3:0] i_avs_byteenable, // Byte lanes
  output logic [31:0] o_avs_readdata, // Read data
  output logic o_avs_waitrequest, // Stall
  input wire pss_pins_t i_pins, // Run, tap, selection pins
  output logic [15:0] o_speed_cmd, // Motor speed command
  output pss_loop_t o_loop, // Effective loop settings
  output logic o_tapping, // Tapping in force
  output logic [15:0] o_ana_filt_set, // Analog filter steps
  output logic o_ana_filt_bypass // Analog filter off
);
  pss_pins_t meta_q;
  pss_pins_t pins_q;
  logic [15:0] div_q;
  logic tick_q;
  logic wait_q;
  logic [15:0] pend_q [0:`PSS_NUM_PARAM-1];
  logic [15:0] act_q [0:`PSS_NUM_PARAM-1];
  logic [1:0] sel_cnt_q;
  logic [2:0] fsel;
  logic filt_busy;
  logic req;
  logic acc;
  logic wr_acc;
  logic apply;
  logic [4:0] widx;
  logic mapped;
  logic is_param;
  logic [15:0] old_v;
  logic [15:0] merged;
  logic [15:0] lim_v;
  logic [31:0] rd_d;
  logic [2:0] idx_d;
  logic run_s;
  logic [15:0] preset;
  logic [15:0] tap_lim;
  logic [15:0] speed_d;
  pss_loop_t loop_d;

  function automatic logic [15:0] pss_limit(input logic [4:0] idx, input logic [15:0] v);
    logic [15:0] r;
    r = v;
    if (idx == `PSS_IDX_TAP_CMD_OFF || idx == `PSS_IDX_NORM_ANA_OFF) begin
      if ($signed(v) > $signed(`PSS_OFF_MAX)) begin
        r = `PSS_OFF_MAX;
      end else if ($signed(v) < $signed(`PSS_OFF_MIN)) begin
        r = `PSS_OFF_MIN;
      end
    end else if (idx == `PSS_IDX_TAP_PROP || idx == `PSS_IDX_TAP_INTEG) begin
      if (v > `PSS_GAIN_MAX) r = `PSS_GAIN_MAX;
    end else if (idx == `PSS_IDX_TAP_MIN_EXC) begin
      if (v > `PSS_EXC_MAX) r = `PSS_EXC_MAX;
    end else if (idx == `PSS_IDX_TAP_CMD_GAIN || idx == `PSS_IDX_NORM_ANA_GAIN) begin
      if (v > `PSS_CMD_GAIN_MAX) r = `PSS_CMD_GAIN_MAX;
    end else if (idx != `PSS_IDX_NORM_PROP && idx != `PSS_IDX_NORM_INTEG) begin
      if (v > `PSS_SPEED_MAX) r = `PSS_SPEED_MAX;
    end
    return r;
  endfunction : pss_limit

  function automatic logic pss_is_imm(input logic [4:0] idx);
    return idx == `PSS_IDX_TAP_CMD_GAIN || idx == `PSS_IDX_TAP_CMD_OFF ||
           idx == `PSS_IDX_NORM_ANA_GAIN || idx == `PSS_IDX_NORM_ANA_OFF;
  endfunction : pss_is_imm

  // Pins are asynchronous to the clock
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      pins_q <= '0;
    end else begin
      meta_q <= i_pins;
      pins_q <= meta_q;
    end
  end

  // 0.8 ms step enable for the selection filter
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q == 16'(P_UNIT_CYC - 1)) begin
      div_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // Bus slave: one wait cycle on every access
  assign req = i_avs_read | i_avs_write;
  assign acc = req & ~wait_q;
  assign widx = i_avs_address[6:2];
  assign mapped = ~i_avs_address[7] && i_avs_address[1:0] == 2'h0 && widx <= `PSS_IDX_STATUS;
  assign is_param = mapped && widx < 5'(`PSS_NUM_PARAM);
  assign wr_acc = acc & i_avs_write & is_param;
  assign apply = acc & i_avs_write & mapped & widx == `PSS_IDX_CTRL &
                 i_avs_byteenable[1] & i_avs_writedata[`PSS_CTRL_APPLY_BIT];
  assign old_v = is_param ? pend_q[widx] : 16'h0000;
  assign merged = {i_avs_byteenable[1] ? i_avs_writedata[15:8] : old_v[15:8],
                   i_avs_byteenable[0] ? i_avs_writedata[7:0] : old_v[7:0]};
  assign lim_v = pss_limit(widx, merged);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  // Stall straight from its flop, low one cycle per access
  assign o_avs_waitrequest = wait_q;

  always_comb begin
    rd_d = 32'h0000_0000;
    if (is_param) begin
      rd_d = {16'h0000, pend_q[widx]};
    end else if (mapped && widx == `PSS_IDX_CTRL) begin
      rd_d = {30'h0000_0000, sel_cnt_q};
    end else if (mapped && widx == `PSS_IDX_STATUS) begin
      rd_d = {25'h000_0000, idx_d, filt_busy, pins_q.tap, run_s, 1'b0};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && wait_q) begin
      o_avs_readdata <= rd_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sel_cnt_q <= 2'h0;
    end else if (acc && i_avs_write && mapped && widx == `PSS_IDX_CTRL && i_avs_byteenable[0]) begin
      sel_cnt_q <= i_avs_writedata[`PSS_CTRL_CNT_LSB +: 2];
    end
  end

  // Software view of every parameter
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < `PSS_NUM_PARAM; i++) begin
        pend_q[i] <= `PSS_PARAM_RST;
      end
    end else if (wr_acc) begin
      pend_q[widx] <= lim_v;
    end
  end

  // Values in force; held ones wait for the power-cycle apply
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < `PSS_NUM_PARAM; i++) begin
        act_q[i] <= `PSS_PARAM_RST;
      end
    end else if (apply) begin
      for (int i = 0; i < `PSS_NUM_PARAM; i++) begin
        act_q[i] <= pend_q[i];
      end
    end else if (wr_acc && pss_is_imm(widx)) begin
      act_q[widx] <= lim_v;
    end
  end

  pss_filter u_filter (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(tick_q),
    .i_setting(act_q[`PSS_IDX_SEL_FILT]),
    .i_raw(pins_q.sel),
    .o_sel(fsel),
    .o_busy(filt_busy)
  );

  // Unassigned selection inputs are ignored
  always_comb begin
    case (sel_cnt_q)
      2'h0: idx_d = 3'h0;
      2'h1: idx_d = {2'h0, fsel[0]};
      2'h2: idx_d = {1'b0, fsel[1:0]};
      default: idx_d = fsel;
    endcase
  end

  assign run_s = pins_q.fwd | pins_q.rev;
  assign preset = act_q[idx_d];
  assign tap_lim = act_q[`PSS_IDX_TAP_MAX] != 16'h0000 ? act_q[`PSS_IDX_TAP_MAX] :
                   act_q[`PSS_IDX_NORM_TAP_MAX];

  always_comb begin
    speed_d = 16'h0000;
    if (run_s) begin
      speed_d = preset;
      if (pins_q.tap && preset > tap_lim) begin
        speed_d = tap_lim;
      end
    end
  end

  // Tapping values fall back to normal ones when zero
  always_comb begin
    loop_d.speed_lim = pins_q.tap ? tap_lim : act_q[`PSS_IDX_NORM_TAP_MAX];
    loop_d.prop = act_q[`PSS_IDX_NORM_PROP];
    loop_d.integ = act_q[`PSS_IDX_NORM_INTEG];
    loop_d.min_exc = 16'h0000;
    loop_d.cmd_gain = act_q[`PSS_IDX_NORM_ANA_GAIN];
    loop_d.cmd_off = act_q[`PSS_IDX_NORM_ANA_OFF];
    if (pins_q.tap) begin
      if (act_q[`PSS_IDX_TAP_PROP] != 16'h0000) loop_d.prop = act_q[`PSS_IDX_TAP_PROP];
      if (act_q[`PSS_IDX_TAP_INTEG] != 16'h0000) loop_d.integ = act_q[`PSS_IDX_TAP_INTEG];
      loop_d.min_exc = act_q[`PSS_IDX_TAP_MIN_EXC];
      if (act_q[`PSS_IDX_TAP_CMD_GAIN] != 16'h0000) loop_d.cmd_gain = act_q[`PSS_IDX_TAP_CMD_GAIN];
      if (act_q[`PSS_IDX_TAP_CMD_OFF] != 16'h0000) loop_d.cmd_off = act_q[`PSS_IDX_TAP_CMD_OFF];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_speed_cmd <= 16'h0000;
      o_loop <= '0;
      o_tapping <= 1'b0;
    end else begin
      o_speed_cmd <= speed_d;
      o_loop <= loop_d;
      o_tapping <= pins_q.tap;
    end
  end

  // Zero setting means the long default; tapping bypasses it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ana_filt_set <= `PSS_ANA_ZERO_SET;
      o_ana_filt_bypass <= 1'b0;
    end else begin
      o_ana_filt_set <= act_q[`PSS_IDX_ANA_FILT] == 16'h0000 ? `PSS_ANA_ZERO_SET :
                        act_q[`PSS_IDX_ANA_FILT];
      o_ana_filt_bypass <= pins_q.tap;
    end
  end

  a_run_preset_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    (run_s && !pins_q.tap && sel_cnt_q == 2'h0) |=> o_speed_cmd == $past(act_q[0]))
    else $error("run alone did not give preset 0");
  a_stop_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    !run_s |=> o_speed_cmd == 16'h0000)
    else $error("speed without run input");
  a_preset_one: assert property (@(posedge i_clk) disable iff (i_rst)
    (run_s && !pins_q.tap && sel_cnt_q != 2'h0 && fsel == 3'h1) |=> o_speed_cmd == $past(act_q[1]))
    else $error("selection 1 did not give preset 1");
  a_preset_two: assert property (@(posedge i_clk) disable iff (i_rst)
    (run_s && !pins_q.tap && sel_cnt_q >= 2'h2 && fsel == 3'h2) |=> o_speed_cmd == $past(act_q[2]))
    else $error("selection 2 did not give preset 2");
  a_preset_three: assert property (@(posedge i_clk) disable iff (i_rst)
    (run_s && !pins_q.tap && sel_cnt_q >= 2'h2 && fsel == 3'h3) |=> o_speed_cmd == $past(act_q[3]))
    else $error("selections 1,2 did not give preset 3");
  a_preset_four: assert property (@(posedge i_clk) disable iff (i_rst)
    (run_s && !pins_q.tap && sel_cnt_q == 2'h3 && fsel == 3'h4) |=> o_speed_cmd == $past(act_q[4]))
    else $error("selection 3 did not give preset 4");
  a_preset_five_six: assert property (@(posedge i_clk) disable iff (i_rst)
    (run_s && !pins_q.tap && sel_cnt_q == 2'h3 && fsel[2] && (fsel[0] ^ fsel[1]))
    |=> o_speed_cmd == $past(act_q[{1'b1, fsel[1:0]}]))
    else $error("selections 1,3 or 2,3 gave wrong preset");
  a_preset_seven: assert property (@(posedge i_clk) disable iff (i_rst)
    (run_s && !pins_q.tap && sel_cnt_q == 2'h3 && fsel == 3'h7) |=> o_speed_cmd == $past(act_q[7]))
    else $error("all selections did not give preset 7");
  a_speed_range: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_speed_cmd[15])
    else $error("speed command above range");
  a_tap_speed_cap: assert property (@(posedge i_clk) disable iff (i_rst)
    (run_s && pins_q.tap) |=> o_speed_cmd <= $past(tap_lim))
    else $error("tapping speed above limit");
  a_tap_prop_pick: assert property (@(posedge i_clk) disable iff (i_rst)
    (pins_q.tap && act_q[`PSS_IDX_TAP_PROP] == 16'h0000) |=> o_loop.prop == $past(act_q[`PSS_IDX_NORM_PROP]))
    else $error("zero tapping gain did not fall back");
  a_tap_integ_pick: assert property (@(posedge i_clk) disable iff (i_rst)
    (pins_q.tap && act_q[`PSS_IDX_TAP_INTEG] != 16'h0000) |=> o_loop.integ == $past(act_q[`PSS_IDX_TAP_INTEG]))
    else $error("tapping integral gain not used");
  a_tap_min_exc: assert property (@(posedge i_clk) disable iff (i_rst)
    pins_q.tap |=> o_loop.min_exc == $past(act_q[`PSS_IDX_TAP_MIN_EXC]) && o_loop.min_exc <= `PSS_EXC_MAX)
    else $error("minimum excitation wrong in tapping");
  a_tap_cmd_gain: assert property (@(posedge i_clk) disable iff (i_rst)
    (pins_q.tap && act_q[`PSS_IDX_TAP_CMD_GAIN] == 16'h0000)
    |=> o_loop.cmd_gain == $past(act_q[`PSS_IDX_NORM_ANA_GAIN]))
    else $error("zero tapping command gain did not fall back");
  a_tap_cmd_off: assert property (@(posedge i_clk) disable iff (i_rst)
    (pins_q.tap && act_q[`PSS_IDX_TAP_CMD_OFF] != 16'h0000)
    |=> o_loop.cmd_off == $past(act_q[`PSS_IDX_TAP_CMD_OFF]))
    else $error("tapping command offset not used");
  a_imm_write: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_acc && widx == `PSS_IDX_TAP_CMD_GAIN) |=> act_q[`PSS_IDX_TAP_CMD_GAIN] == $past(lim_v))
    else $error("immediate parameter not applied on write");
  a_ana_bypass: assert property (@(posedge i_clk) disable iff (i_rst)
    pins_q.tap |=> o_ana_filt_bypass ##0 o_tapping)
    else $error("analog filter not bypassed in tapping");
  a_held_write: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_acc && widx == `PSS_IDX_PRESET0 && !apply) |=> $stable(act_q[0]))
    else $error("held parameter changed before apply");
  a_wait_once: assert property (@(posedge i_clk) disable iff (i_rst)
    (req && o_avs_waitrequest) |=> !o_avs_waitrequest)
    else $error("access not answered after one wait");
  a_wait_rises: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("stall stayed low past one cycle");
  a_preset_clamp: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_acc && widx == 5'h07) |=> pend_q[7] <= `PSS_SPEED_MAX)
    else $error("preset speed stored above range");
  a_tap_prop_use: assert property (@(posedge i_clk) disable iff (i_rst)
    (pins_q.tap && act_q[`PSS_IDX_TAP_PROP] != 16'h0000) |=> o_loop.prop == $past(act_q[`PSS_IDX_TAP_PROP]))
    else $error("tapping proportional gain not used");
  a_tap_integ_fall: assert property (@(posedge i_clk) disable iff (i_rst)
    (pins_q.tap && act_q[`PSS_IDX_TAP_INTEG] == 16'h0000) |=> o_loop.integ == $past(act_q[`PSS_IDX_NORM_INTEG]))
    else $error("zero tapping integral gain did not fall back");
  a_tap_lim_fall: assert property (@(posedge i_clk) disable iff (i_rst)
    (run_s && pins_q.tap && act_q[`PSS_IDX_TAP_MAX] == 16'h0000 && preset > act_q[`PSS_IDX_NORM_TAP_MAX])
    |=> o_speed_cmd == $past(act_q[`PSS_IDX_NORM_TAP_MAX]))
    else $error("zero tapping limit did not fall back");
  a_cmd_gain_use: assert property (@(posedge i_clk) disable iff (i_rst)
    (pins_q.tap && act_q[`PSS_IDX_TAP_CMD_GAIN] != 16'h0000)
    |=> o_loop.cmd_gain == $past(act_q[`PSS_IDX_TAP_CMD_GAIN]))
    else $error("tapping command gain not used");
  a_cmd_off_fall: assert property (@(posedge i_clk) disable iff (i_rst)
    (pins_q.tap && act_q[`PSS_IDX_TAP_CMD_OFF] == 16'h0000)
    |=> o_loop.cmd_off == $past(act_q[`PSS_IDX_NORM_ANA_OFF]))
    else $error("zero tapping offset did not fall back");
  a_exc_outside: assert property (@(posedge i_clk) disable iff (i_rst)
    !pins_q.tap |=> o_loop.min_exc == 16'h0000)
    else $error("minimum excitation outside tapping");
  a_ana_zero_long: assert property (@(posedge i_clk) disable iff (i_rst)
    act_q[`PSS_IDX_ANA_FILT] == 16'h0000 |=> o_ana_filt_set == `PSS_ANA_ZERO_SET)
    else $error("zero analog filter setting not long default");
  a_apply_copy: assert property (@(posedge i_clk) disable iff (i_rst)
    apply |=> act_q[`PSS_IDX_SEL_FILT] == $past(pend_q[`PSS_IDX_SEL_FILT]))
    else $error("held parameter not applied at power cycle");
endmodule : pss_top

/* File: verilog/pss_map.svh */
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH
// Summary of operation
// - Run input alone commands preset speed 0
// - Only selection 1 on uses preset speed 1
// - Only selection 2 on uses preset 2
// - Selections 1 and 2 on use preset 3
// - Only selection 3 on uses preset 4
// - Selections 1,3 give 5; 2,3 give 6
// - All three selections on use preset 7
// - Preset speeds range 0 to 32767, default 0
// - Selection filter 0.8 ms per step; 0 bypasses
// - Tapping caps speed; zero falls back to normal
// - Tapping proportional gain, zero uses normal gain
// - Tapping integral gain, zero uses normal gain
// - Tapping applies minimum excitation rate 0-100 percent
// - Tapping command gain, zero uses normal gain
// - Tapping command offset, zero uses normal offset
// - Command gain and offset apply on write
// - Analog filter 0.8 ms steps, zero 25.6 ms

// Register index; byte offset is index times four
`define PSS_IDX_PRESET0 5'h00
`define PSS_IDX_SEL_FILT 5'h08
`define PSS_IDX_TAP_MAX 5'h09
`define PSS_IDX_TAP_PROP 5'h0A
`define PSS_IDX_TAP_INTEG 5'h0B
`define PSS_IDX_TAP_MIN_EXC 5'h0C
`define PSS_IDX_TAP_CMD_GAIN 5'h0D
`define PSS_IDX_TAP_CMD_OFF 5'h0E
`define PSS_IDX_NORM_TAP_MAX 5'h0F
`define PSS_IDX_NORM_PROP 5'h10
`define PSS_IDX_NORM_INTEG 5'h11
`define PSS_IDX_NORM_ANA_GAIN 5'h12
`define PSS_IDX_NORM_ANA_OFF 5'h13
`define PSS_IDX_ANA_FILT 5'h14
`define PSS_IDX_CTRL 5'h15
`define PSS_IDX_STATUS 5'h16
`define PSS_NUM_PARAM 21

// Control register fields
`define PSS_CTRL_CNT_LSB 0
`define PSS_CTRL_APPLY_BIT 8

// Reset value and setting limits
`define PSS_PARAM_RST 16'h0000
`define PSS_SPEED_MAX 16'h7FFF
`define PSS_GAIN_MAX 16'h03E8
`define PSS_EXC_MAX 16'h0064
`define PSS_CMD_GAIN_MAX 16'h09C4
`define PSS_OFF_MAX 16'h03E7
`define PSS_OFF_MIN 16'hFC19

// Timing
`define PSS_CLK_PERIOD_NS 25
`define PSS_FILT_UNIT_NS 800000
`define PSS_FILT_UNIT_CYC (`PSS_FILT_UNIT_NS / `PSS_CLK_PERIOD_NS)
`define PSS_ANA_ZERO_NS 25600000
`define PSS_ANA_ZERO_SET 16'(`PSS_ANA_ZERO_NS / `PSS_FILT_UNIT_NS)
`endif

/* File: verilog/pss_pkg.sv */
package pss_pkg;
  typedef struct packed {
    logic fwd;
    logic rev;
    logic tap;
    logic [2:0] sel;
  } pss_pins_t;

  typedef struct packed {
    logic [15:0] speed_lim;
    logic [15:0] prop;
    logic [15:0] integ;
    logic [15:0] min_exc;
    logic [15:0] cmd_gain;
    logic [15:0] cmd_off;
  } pss_loop_t;

  typedef enum logic {
    PSS_FLT_IDLE,
    PSS_FLT_WAIT
  } pss_flt_st_t;
endpackage : pss_pkg

/* File: verilog/pss_filter.sv */
`include "pss_map.svh"
module pss_filter import pss_pkg::*; (
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Sync reset
  input wire logic i_tick, // One 0.8 ms step
  input wire logic [15:0] i_setting, // Steps of stability
  input wire logic [2:0] i_raw, // Synchronised selection
  output logic [2:0] o_sel, // Accepted selection
  output logic o_busy // Change pending
);
  pss_flt_st_t st_q;
  logic [2:0] cand_q;
  logic [15:0] cnt_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= PSS_FLT_IDLE;
      cand_q <= 3'h0;
      cnt_q <= 16'h0000;
      o_sel <= 3'h0;
    end else begin
      case (st_q)
        PSS_FLT_IDLE: begin
          if (i_raw != o_sel) begin
            if (i_setting == 16'h0000) begin
              o_sel <= i_raw;
            end else begin
              cand_q <= i_raw;
              cnt_q <= 16'h0000;
              st_q <= PSS_FLT_WAIT;
            end
          end
        end
        PSS_FLT_WAIT: begin
          // Any bounce restarts the wait
          if (i_raw != cand_q) begin
            st_q <= PSS_FLT_IDLE;
          end else if (i_tick) begin
            if (cnt_q + 16'h0001 >= i_setting) begin
              o_sel <= cand_q;
              st_q <= PSS_FLT_IDLE;
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end
        end
        default: st_q <= PSS_FLT_IDLE;
      endcase
    end
  end

  assign o_busy = (st_q == PSS_FLT_WAIT);

  a_filter_bypass: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q == PSS_FLT_IDLE && i_setting == 16'h0000 && i_raw != o_sel) |=> o_sel == $past(i_raw))
    else $error("unfiltered selection not taken");
  a_filter_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q == PSS_FLT_WAIT && !i_tick) |=> $stable(o_sel))
    else $error("selection changed between steps");
endmodule : pss_filter

/* File: tb/pss_pins_model.sv */
module pss_pins_model import pss_pkg::*; (
  input wire logic i_clk, // Bench clock
  input wire logic i_fwd, // Forward run contact
  input wire logic i_rev, // Reverse run contact
  input wire logic i_tap, // Tapping contact
  input wire logic [2:0] i_sel, // Selection contacts 1..3
  output pss_pins_t o_pins // Levels toward the drive
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts move only on a clock edge and then hold as levels
  always_ff @(posedge i_clk) begin
    o_pins <= '{fwd: i_fwd, rev: i_rev, tap: i_tap, sel: i_sel};
  end
endmodule : pss_pins_model

/* File: tb/testbench.sv */
module testbench import pss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_req;
  logic fwd = 1'b0;
  logic rev = 1'b0;
  logic tap = 1'b0;
  logic [2:0] sel = 3'h0;
  pss_pins_t pins;
  logic [15:0] speed;
  pss_loop_t loop_set;
  logic tapping;
  logic [15:0] filt_set;
  logic bypass;
  int num_errors = 0;
  int checked = 0;

  pss_pins_model pins_u (.i_clk(i_clk), .i_fwd(fwd), .i_rev(rev), .i_tap(tap), .i_sel(sel), .o_pins(pins));
  // Short filter step keeps the selection filter test brief
  pss_top #(.P_UNIT_CYC(4)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_pins(pins), .o_speed_cmd(speed), .o_loop(loop_set),
    .o_tapping(tapping), .o_ana_filt_set(filt_set), .o_ana_filt_bypass(bypass));

  initial begin
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wt

  // Hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic is_rd, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    addr <= a;
    rd <= is_rd;
    wr <= !is_rd;
    wdata <= {16'h0000, d};
    do begin
      @(posedge i_clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      $display("mismatch at %0t bus timeout waitrequest %h expected %h", $time, wait_req, 1'b0);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 16'h0000, q);
    chk(q, exp);
  endtask : rchk

  task automatic pin_set(input logic f, input logic [2:0] s);
    @(posedge i_clk);
    fwd <= f;
    sel <= s;
    wt(6);
  endtask : pin_set

  function automatic logic [15:0] pv(input int i);
    return 16'h0100 + 16'(i) * 16'h0111;
  endfunction : pv

  task automatic t_reset;
    for (int i = 0; i < 15; i++) begin
      rchk(8'(i * 4), 32'h0);
    end
    rchk(8'h80, 32'h0);
    chk(speed, 16'h0000);
    chk(filt_set, 16'h0020);
    $display("reset test done");
  endtask : t_reset

  task automatic t_presets;
    for (int i = 0; i < 8; i++) begin
      wreg(8'(i * 4), pv(i));
    end
    wreg(8'h80, 16'h1234);
    rchk(8'h80, 32'h0);
    wreg(8'h54, 16'h0003);
    pin_set(1'b1, 3'h0);
    chk(speed, 16'h0000);
    rchk(8'h04, {16'h0, pv(1)});
    wreg(8'h54, 16'h0103);
    wt(4);
    for (int s = 0; s < 8; s++) begin
      pin_set(1'b1, 3'(s));
      chk(speed, pv(s));
    end
    wreg(8'h54, 16'h0001);
    pin_set(1'b1, 3'h6);
    chk(speed, pv(0));
    pin_set(1'b1, 3'h7);
    chk(speed, pv(1));
    wreg(8'h54, 16'h0002);
    pin_set(1'b1, 3'h6);
    chk(speed, pv(2));
    @(posedge i_clk);
    rev <= 1'b1;
    pin_set(1'b0, 3'h7);
    chk(speed, pv(3));
    @(posedge i_clk);
    rev <= 1'b0;
    wt(6);
    chk(speed, 16'h0000);
    $display("preset test done");
  endtask : t_presets

  task automatic t_filter;
    wreg(8'h1C, 16'hFFFF);
    wreg(8'h20, 16'h0003);
    wreg(8'h54, 16'h0103);
    pin_set(1'b1, 3'h7);
    wt(20);
    chk(speed, 16'h7FFF);
    @(posedge i_clk);
    sel <= 3'h5;
    wt(10);
    chk(speed, 16'h7FFF);
    wt(15);
    chk(speed, pv(5));
    wreg(8'h20, 16'h0000);
    wreg(8'h54, 16'h0103);
    pin_set(1'b1, 3'h7);
    $display("filter test done");
  endtask : t_filter

  task automatic t_tap;
    wreg(8'h3C, 16'h0200);
    wreg(8'h40, 16'h0030);
    wreg(8'h44, 16'h0031);
    wreg(8'h48, 16'h0400);
    wreg(8'h4C, 16'h0010);
    wreg(8'h54, 16'h0103);
    @(posedge i_clk);
    tap <= 1'b1;
    wt(6);
    chk(loop_set, {16'h0200, 16'h0030, 16'h0031, 16'h0000, 16'h0400, 16'h0010});
    chk(speed, 16'h0200);
    chk({tapping, bypass}, 2'b11);
    rchk(8'h58, 32'h0000_0076);
    rchk(8'h54, 32'h0000_0003);
    wreg(8'h24, 16'h0100);
    wreg(8'h28, 16'h0050);
    wreg(8'h2C, 16'h0050);
    wreg(8'h30, 16'h00FF);
    rchk(8'h30, 32'h0000_0064);
    wreg(8'h34, 16'h0500);
    wreg(8'h38, 16'hFFFB);
    wt(3);
    chk(loop_set, {16'h0200, 16'h0030, 16'h0031, 16'h0000, 16'h0500, 16'hFFFB});
    wreg(8'h50, 16'h0005);
    wreg(8'h54, 16'h0103);
    wt(3);
    chk(loop_set, {16'h0100, 16'h0050, 16'h0050, 16'h0064, 16'h0500, 16'hFFFB});
    chk(speed, 16'h0100);
    chk(filt_set, 16'h0005);
    @(posedge i_clk);
    tap <= 1'b0;
    wt(6);
    chk(bypass, 1'b0);
    chk(speed, 16'h7FFF);
    $display("tapping test done");
  endtask : t_tap

  initial begin
    wt(10);
    i_rst <= 1'b0;
    wt(3);
    t_reset();
    t_presets();
    t_filter();
    t_tap();
    summarize();
  end

  // Whole run takes a few hundred cycles; the 20000-cycle limit leaves ample margin
  initial begin
    #(25 * 20000);
    num_errors++;
    summarize();
  end
endmodule : testbench
